//--- include/arxcdr_pkg.sv
// Package for the asynchronous receive clock and data recovery block.
// Assumes a single peripheral clock domain and external sample ticks.
package arxcdr_pkg;
  // Receive speed select encodings
  localparam logic [1:0] SPEED_NORMAL = 2'h0;
  localparam logic [1:0] SPEED_DOUBLE = 2'h1;
  // Samples per bit in each mode
  localparam int SAMPLES_NORMAL = 16;
  localparam int SAMPLES_DOUBLE = 8;
  // First voting sample number in each mode
  localparam int VOTE_FIRST_NORMAL = 8;
  localparam int VOTE_FIRST_DOUBLE = 4;
  // Middle voting sample number in each mode
  localparam int VOTE_MID_NORMAL = 9;
  localparam int VOTE_MID_DOUBLE = 5;
  // Frame data-plus-parity length limits
  localparam int DBITS_MIN = 5;
  localparam int DBITS_MAX = 10;
  // Reset values
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [2:0] VOTE_RESET = 3'h7;
  // Receiver states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } arxcdr_state_t;
endpackage

//--- src/arxcdr_sync.sv
// Two-flop synchroniser for the receive line.
// Assumes the input is asynchronous to REF_CLK domain clk_i.
`timescale 1ns/1ps
module arxcdr_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  // First stage; read only by the second stage
  logic meta_q;

  // Two stages, reset to idle line level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= arxcdr_pkg::SYNC_RESET[0];
      sync_o <= arxcdr_pkg::SYNC_RESET[1];
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

//--- src/arxcdr_top.sv
// Asynchronous receive clock and data recovery front end.
// Assumes SAMPLE_TICK_I comes from a baud generator on the same clock,
// pulsing at 16x baud (normal) or 8x baud (double speed).
// Summary of operation
// RULE_01 - Normal mode samples sixteen times per bit
// RULE_02 - Double speed samples eight times per bit
// RULE_03 - Falling edge starts; first low is sample one
// RULE_04 - Start vote samples 8-10 or 4-6
// RULE_05 - Fewer than two lows rejects start
// RULE_06 - Each bit decided by centre-sample majority
// RULE_07 - Only the first stop bit checked
// RULE_08 - Low stop bit sets frame error
// RULE_09 - Next start allowed right after stop vote
// RULE_10 - Double speed doubles baud per divider
// RULE_11 - Normal mode tolerates tabulated rate window
// RULE_12 - Double speed tolerates narrower rate window
// RULE_13 - Remote transmitter keeps half error budget
// RULE_14 - Tolerance follows from voting sample positions
// RULE_15 - Frames of five to ten data bits
// RULE_16 - Sample counter restarts at accepted start
// RULE_17 - Line synchronised; sampling advances on ticks
`timescale 1ns/1ps
module arxcdr_top #(
  parameter int DATA_W = arxcdr_pkg::DBITS_MAX
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic RX_ENABLE_I,
  input wire logic [1:0] RECEIVE_SPEED_SELECT_I,
  input wire logic [3:0] FRAME_BITS_I,
  input wire logic SAMPLE_TICK_I,
  input wire logic RXD_I,
  output logic [DATA_W-1:0] RX_DATA_O,
  output logic RX_VALID_O,
  output logic FRAME_ERROR_O,
  output logic START_REJECT_O,
  output logic BUSY_O
);
  // Sample numbers in the package, as 5-bit counts
  // Five bits hold sixteen; four bits hold the longest frame length
  localparam logic [4:0] S_N = 5'(arxcdr_pkg::SAMPLES_NORMAL);
  localparam logic [4:0] S_D = 5'(arxcdr_pkg::SAMPLES_DOUBLE);
  localparam logic [4:0] F_N = 5'(arxcdr_pkg::VOTE_FIRST_NORMAL);
  localparam logic [4:0] F_D = 5'(arxcdr_pkg::VOTE_FIRST_DOUBLE);
  localparam logic [4:0] M_N = 5'(arxcdr_pkg::VOTE_MID_NORMAL);
  localparam logic [4:0] M_D = 5'(arxcdr_pkg::VOTE_MID_DOUBLE);
  localparam logic [3:0] D_MIN = 4'(arxcdr_pkg::DBITS_MIN);
  localparam logic [3:0] D_MAX = 4'(arxcdr_pkg::DBITS_MAX);

  // Synchronised line level
  logic rx_sync;
  // Previous sampled line level, for edge detection
  logic rx_prev_q;
  // Receiver state
  arxcdr_pkg::arxcdr_state_t state_q;
  // Sample number within the current bit, 1-based
  logic [4:0] smp_q;
  // Bits received so far in the data field
  logic [3:0] bit_q;
  // Data shift register, LSB first on the line
  logic [DATA_W-1:0] shift_q;
  // Latched mode and length for the current frame
  // A mode change mid-frame takes effect only at the next start edge
  logic dbl_q;
  logic [3:0] len_q;
  // Voter signals
  logic vote_clear;
  logic vote_shift;
  logic [2:0] vote_smp;
  logic vote_maj;
  // Decoded per-mode figures
  logic [4:0] s_per_bit;
  logic [4:0] s_first;
  logic [4:0] s_last;
  logic in_window;
  logic last_vote;
  logic fall;

  // Samples per bit for a mode select
  function automatic logic [4:0] spb(input logic dbl);
    spb = dbl ? S_D : S_N;
  endfunction

  // First voting sample for a mode select
  function automatic logic [4:0] vfirst(input logic dbl);
    vfirst = dbl ? F_D : F_N;
  endfunction

  // RULE_17 line sync
  arxcdr_sync u_sync (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(RXD_I),
    .sync_o(rx_sync)
  );

  // Centre-sample voter shared by start, data and stop
  arxcdr_vote u_vote (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .clear_i(vote_clear),
    .shift_i(vote_shift),
    .bit_i(rx_sync),
    .samples_o(vote_smp),
    .majority_o(vote_maj)
  );

  // RULE_01 RULE_02 RULE_14 per-mode figures
  // RULE_11 RULE_12 windows follow from these
  // The rate tolerance is not a separate check: it falls out of where
  // the three votes sit inside each bit, so moving s_first moves both
  // limits of the window at once
  always_comb begin
    s_per_bit = spb(dbl_q);
    s_first = vfirst(dbl_q);
    s_last = s_first + 5'h02;
  end

  // Window and edge decode
  // The voter only shifts inside the window, so it holds the two
  // earlier votes of the current bit when the third one arrives
  always_comb begin
    in_window = (smp_q >= s_first) && (smp_q <= s_last);
    last_vote = SAMPLE_TICK_I && (smp_q == s_last);
    fall = SAMPLE_TICK_I && rx_prev_q && !rx_sync;
    vote_shift = SAMPLE_TICK_I && in_window && (state_q != arxcdr_pkg::ST_IDLE);
    vote_clear = (state_q == arxcdr_pkg::ST_IDLE);
  end

  // Line level as seen at each sample tick
  // Resets high, matching the idle line, so no false edge after reset
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rx_prev_q <= 1'b1;
    end else if (SAMPLE_TICK_I) begin
      rx_prev_q <= rx_sync;
    end
  end

  // Frame sequencing state machine
  // Everything except a disable moves on sample ticks only; between ticks the counters
  // hold, so the tick rate alone sets the bit time
  // Edges seen while busy are ignored until the stop vote
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      state_q <= arxcdr_pkg::ST_IDLE;
      smp_q <= 5'h01;
      bit_q <= 4'h0;
      dbl_q <= 1'b0;
      len_q <= D_MIN;
    end else if (!RX_ENABLE_I) begin
      // Disabling drops any reception in progress
      state_q <= arxcdr_pkg::ST_IDLE;
      smp_q <= 5'h01;
    end else if (SAMPLE_TICK_I) begin
      case (state_q)
        arxcdr_pkg::ST_IDLE: begin
          // RULE_03 edge starts sampling
          if (rx_prev_q && !rx_sync) begin
            state_q <= arxcdr_pkg::ST_START;
            // First low sample is sample one, so next is two
            smp_q <= 5'h02;
            // RULE_10 mode latched per frame
            dbl_q <= (RECEIVE_SPEED_SELECT_I == arxcdr_pkg::SPEED_DOUBLE);
            // RULE_15 length clamped to five..ten
            if (FRAME_BITS_I < D_MIN) begin
              len_q <= D_MIN;
            end else if (FRAME_BITS_I > D_MAX) begin
              len_q <= D_MAX;
            end else begin
              len_q <= FRAME_BITS_I;
            end
          end
        end
        arxcdr_pkg::ST_START: begin
          if (smp_q == s_last) begin
            // RULE_04 RULE_05 two of three lows accept
            if (vote_maj_next() == 1'b0) begin
              state_q <= arxcdr_pkg::ST_DATA;
              // RULE_16 counter referenced to start
              smp_q <= s_last + 5'h01;
              bit_q <= 4'h0;
            end else begin
              state_q <= arxcdr_pkg::ST_IDLE;
              smp_q <= 5'h01;
            end
          end else begin
            smp_q <= smp_q + 5'h01;
          end
        end
        arxcdr_pkg::ST_DATA: begin
          // RULE_06 vote each bit, count to length
          // Counter wraps at the bit length and keeps its start phase
          if (smp_q == s_last) begin
            if (bit_q == len_q - 4'h1) begin
              state_q <= arxcdr_pkg::ST_STOP;
            end
            bit_q <= bit_q + 4'h1;
          end
          smp_q <= (smp_q == s_per_bit) ? 5'h01 : smp_q + 5'h01;
        end
        arxcdr_pkg::ST_STOP: begin
          // RULE_07 RULE_09 end after first stop vote
          // Further stop bits fall into idle, where a high line is quiet
          // Leaving at the last vote lets a new start follow at once
          if (smp_q == s_last) begin
            state_q <= arxcdr_pkg::ST_IDLE;
            smp_q <= 5'h01;
          end else begin
            smp_q <= (smp_q == s_per_bit) ? 5'h01 : smp_q + 5'h01;
          end
        end
        default: begin
          state_q <= arxcdr_pkg::ST_IDLE;
          smp_q <= 5'h01;
        end
      endcase
    end
  end

  // Majority including the sample arriving this tick
  // The third vote is still on the line, not yet in the voter, so it
  // is folded in here to decide at the very tick it is taken
  function automatic logic vote_maj_next();
    vote_maj_next = (vote_smp[0] & vote_smp[1]) |
                    (vote_smp[1] & rx_sync) |
                    (vote_smp[0] & rx_sync);
  endfunction

  // RULE_06 data shift, LSB first, right-aligned at end
  // Bits enter at the top; a short frame is shifted down at the end
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      shift_q <= '0;
    end else if (state_q == arxcdr_pkg::ST_DATA && last_vote) begin
      shift_q <= {vote_maj_next(), shift_q[DATA_W-1:1]};
    end
  end

  // Completed character and frame error outputs
  // Frame error holds with the data until the next completed frame
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      RX_DATA_O <= '0;
      RX_VALID_O <= 1'b0;
      FRAME_ERROR_O <= 1'b0;
    end else if (RX_ENABLE_I && state_q == arxcdr_pkg::ST_STOP &&
                 last_vote) begin
      // Align so the first received bit lands in bit 0
      RX_DATA_O <= shift_q >> (D_MAX - len_q);
      RX_VALID_O <= 1'b1;
      // RULE_08 low stop bit flags error
      FRAME_ERROR_O <= !vote_maj_next();
    end else begin
      RX_VALID_O <= 1'b0;
    end
  end

  // Rejected start pulse and busy level
  // Busy also covers the tick of the start edge itself, so it rises
  // as soon as a frame may begin
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      START_REJECT_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      // RULE_05 report rejected start
      START_REJECT_O <= RX_ENABLE_I && SAMPLE_TICK_I &&
                        state_q == arxcdr_pkg::ST_START &&
                        smp_q == s_last && vote_maj_next();
      BUSY_O <= (state_q != arxcdr_pkg::ST_IDLE) || fall;
    end
  end
endmodule

//--- src/arxcdr_vote.sv
// Three-sample majority voter with sample shift register.
// Assumes shift_i pulses once per accepted voting sample.
`timescale 1ns/1ps
module arxcdr_vote (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [2:0] samples_o,
  output logic majority_o
);
  // Held voting samples, newest in bit 0
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      samples_o <= arxcdr_pkg::VOTE_RESET;
    end else if (clear_i) begin
      samples_o <= arxcdr_pkg::VOTE_RESET;
    end else if (shift_i) begin
      samples_o <= {samples_o[1:0], bit_i};
    end
  end

  // Two of three decide the level
  always_comb begin
    majority_o = (samples_o[0] & samples_o[1]) |
                 (samples_o[1] & samples_o[2]) |
                 (samples_o[0] & samples_o[2]);
  end
endmodule

//--- verif/arxcdr_monitor.sv
// Checker on the receive front end ports, attached by bind.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module arxcdr_monitor #(
  parameter int DATA_W = 10
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic SAMPLE_TICK_I,
  input wire logic RXD_I,
  input wire logic [DATA_W-1:0] RX_DATA_O,
  input wire logic RX_VALID_O,
  input wire logic START_REJECT_O,
  input wire logic BUSY_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Completion is a single-cycle strobe
  sequence s_valid_pulse; RX_VALID_O ##1 !RX_VALID_O; endsequence
  // Idle receiver watching a high line
  sequence s_quiet; (!BUSY_O && RXD_I) [*4]; endsequence
  property p_valid_pulse; RX_VALID_O |-> s_valid_pulse; endproperty
  property p_reject_pulse; START_REJECT_O |=> !START_REJECT_O; endproperty
  property p_not_both; !(RX_VALID_O && START_REJECT_O); endproperty
  property p_valid_tick; RX_VALID_O |-> $past(SAMPLE_TICK_I); endproperty
  property p_reject_tick; START_REJECT_O |-> $past(SAMPLE_TICK_I);
  endproperty
  property p_busy_tick; $rose(BUSY_O) |-> $past(SAMPLE_TICK_I); endproperty
  property p_data_hold; $changed(RX_DATA_O) |-> RX_VALID_O; endproperty
  property p_quiet_idle; s_quiet |=> !BUSY_O; endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("valid wider than one cycle");
  a_reject_pulse: assert property (p_reject_pulse)
    else $error("reject wider than one cycle");
  a_not_both: assert property (p_not_both)
    else $error("valid and reject together");
  a_valid_tick: assert property (p_valid_tick)
    else $error("valid not after a tick");
  a_reject_tick: assert property (p_reject_tick)
    else $error("reject not after a tick");
  a_busy_tick: assert property (p_busy_tick)
    else $error("busy rose without a tick");
  a_data_hold: assert property (p_data_hold)
    else $error("data moved without valid");
  a_quiet_idle: assert property (p_quiet_idle)
    else $error("busy on a quiet line");
endmodule
bind arxcdr_top arxcdr_monitor #(.DATA_W(DATA_W)) u_mon (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .SAMPLE_TICK_I(SAMPLE_TICK_I),
  .RXD_I(RXD_I), .RX_DATA_O(RX_DATA_O), .RX_VALID_O(RX_VALID_O),
  .START_REJECT_O(START_REJECT_O), .BUSY_O(BUSY_O));

//--- verif/arxcdr_tx_model.sv
// Remote serial transmitter with its own bit time in clocks.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module arxcdr_tx_model (
  input wire logic clk_i,
  output logic line_o
);
  // Line idles high before any traffic
  initial line_o = 1'b1;
  // Hold one level for a number of clocks
  task automatic level(input logic v, input int k);
    line_o <= v;
    repeat (k) @(posedge clk_i);
  endtask
  // own rate, 5 to 10 bits
  task automatic send(input logic [9:0] d, input int n, input logic stop,
                      input int cpb);
    level(1'b0, cpb);
    for (int i = 0; i < n; i++) begin
      level(d[i], cpb);
    end
    // One stop bit; caller decides what follows
    level(stop, cpb);
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the receive front end.
// Assumes ticks every second clock, i.e. 16 or 8 ticks per bit.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_en = 1'b0;
  logic [1:0] speed = 2'h0;
  logic [3:0] fbits = 4'h8;
  logic tick = 1'b0;
  logic rxd;
  logic [9:0] rx_data;
  logic rx_valid, ferr, rej, busy;
  logic [9:0] got_d;
  logic got_fe;
  int err_total = 0;
  int n_tests = 0;
  int got_n = 0;
  int rej_n = 0;
  // Clock of 100 ns
  always #50 ref_clk = ~ref_clk;
  // Tick every second cycle keeps the gating honest
  always @(posedge ref_clk) tick <= ~tick;
  arxcdr_top #(.DATA_W(10)) DUT (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
    .RX_ENABLE_I(rx_en), .RECEIVE_SPEED_SELECT_I(speed),
    .FRAME_BITS_I(fbits), .SAMPLE_TICK_I(tick), .RXD_I(rxd),
    .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .FRAME_ERROR_O(ferr),
    .START_REJECT_O(rej), .BUSY_O(busy));
  arxcdr_tx_model u_tx (.clk_i(ref_clk), .line_o(rxd));
  // Capture strobes as they stand
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      got_n++;
      got_d = rx_data;
      got_fe = ferr;
    end
    if (rej === 1'b1) rej_n++;
  end
  task automatic chk(input string what, input logic [9:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic frame(input logic [1:0] m, input int n,
                       input logic [9:0] d, input logic stop, input int cpb);
    speed <= m;
    fbits <= 4'(n);
    u_tx.send(d, n, stop, cpb);
  endtask
  // Idle, then judge count, data and error flag
  task automatic expect_rx(input int c, input logic [9:0] d, input logic fe);
    u_tx.level(1'b1, 64);
    chk("count", 10'(c), 10'(got_n));
    chk("data", d, got_d);
    chk("frame error", {9'h0, fe}, {9'h0, got_fe});
    got_n = 0;
  endtask
  task automatic t_normal();
    frame(2'h0, 8, 10'h0a5, 1'b1, 32);
    frame(2'h0, 10, 10'h2c3, 1'b1, 32);
    expect_rx(2, 10'h2c3, 1'b0);
    $display("normal done");
  endtask
  task automatic t_double();
    frame(2'h1, 5, 10'h3f5, 1'b1, 16);
    expect_rx(1, 10'h015, 1'b0);
    frame(2'h2, 6, 10'h02a, 1'b1, 32);
    expect_rx(1, 10'h02a, 1'b0);
    $display("double done");
  endtask
  task automatic t_ferr();
    frame(2'h0, 10, 10'h155, 1'b0, 32);
    expect_rx(1, 10'h155, 1'b1);
    frame(2'h0, 7, 10'h05a, 1'b1, 32);
    expect_rx(1, 10'h05a, 1'b0);
    $display("frame error done");
  endtask
  task automatic t_rate();
    frame(2'h0, 8, 10'h03c, 1'b1, 31);
    expect_rx(1, 10'h03c, 1'b0);
    frame(2'h0, 8, 10'h0c3, 1'b1, 33);
    expect_rx(1, 10'h0c3, 1'b0);
    $display("rate done");
  endtask
  task automatic t_reject();
    rej_n = 0;
    u_tx.level(1'b0, 6);
    u_tx.level(1'b1, 64);
    chk("rejects", 10'h001, 10'(rej_n));
    chk("count", 10'h000, 10'(got_n));
    $display("reject done");
  endtask
  task automatic t_abort();
    // All-ones data leaves no edge after the abort
    fork
      frame(2'h0, 8, 10'h0ff, 1'b1, 32);
      begin
        repeat (100) @(posedge ref_clk);
        rx_en <= 1'b0;
        @(posedge ref_clk);
        rx_en <= 1'b1;
      end
    join
    u_tx.level(1'b1, 64);
    chk("count", 10'h000, 10'(got_n));
    chk("busy", 10'h000, {9'h0, busy});
    $display("abort done");
  endtask
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Whole run is some 3300 clocks
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rx_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_normal();
    t_double();
    t_ferr();
    t_rate();
    t_reject();
    t_abort();
    give_verdict();
  end
endmodule
